// ===== logic/tkcc_map.svh
`ifndef TKCC_MAP_SVH
`define TKCC_MAP_SVH

// Register indices; byte address is four times the index
`define TKCC_IDX_CFGC 16'hA01A
`define TKCC_IDX_CTRL 16'hA01B
`define TKCC_IDX_HDTYL 16'hA01C
`define TKCC_IDX_HDTYH 16'hA01D
`define TKCC_IDX_LDTYL 16'hA01E
`define TKCC_IDX_LDTYH 16'hA01F
`define TKCC_IDX_BASEL 16'hA028
`define TKCC_IDX_BASEH 16'hA029
`define TKCC_IDX_THDL 16'hA02A
`define TKCC_IDX_THDH 16'hA02B
`define TKCC_IDX_BIAS 16'hA02C

// Reset value of every register byte
`define TKCC_RST_BYTE 8'h00

// Control/status byte fields
`define TKCC_CTRL_NOISE 2
`define TKCC_CTRL_IRQ 1
`define TKCC_CTRL_START 0

// Bias byte fields
`define TKCC_BIAS_CUR 7
`define TKCC_BIAS_RES 6

// Sequence lengths in converter cycles
`define TKCC_CYC_0 17'h0_0400
`define TKCC_CYC_1 17'h0_0800
`define TKCC_CYC_2 17'h0_1000
`define TKCC_CYC_3 17'h0_2000
`define TKCC_CYC_4 17'h0_3000
`define TKCC_CYC_5 17'h0_4000
`define TKCC_CYC_6 17'h0_8000
`define TKCC_CYC_7 17'h1_0000

// Repeat totals
`define TKCC_RPT_0 5'h01
`define TKCC_RPT_1 5'h04
`define TKCC_RPT_2 5'h08
`define TKCC_RPT_3 5'h10

// Auto start delay unit is 256 converter cycles
`define TKCC_DLY_SHIFT 8
// Smallest moving average depth is 2**5
`define TKCC_AVG_SHIFT 3'h5

`define TKCC_RESP_OKAY 2'h0
`define TKCC_RESP_SLVERR 2'h2

`endif

// ===== logic/tkcc_pkg.sv
package tkcc_pkg;

   typedef enum logic [1:0] {ST_IDLE, ST_DELAY, ST_RUN, ST_DONE} tkcc_fsm_t;

   typedef struct packed {
      logic [1:0] avgDepth;
      logic [2:0] cycleSel;
      logic baseInit;
      logic thrRel;
      logic noiseFiltEn;
   } tkcc_cfgc_t;

   // Drive toward the analog front end
   typedef struct packed {
      logic [2:0] chargeCapSel;
      logic randomTimingEn;
      logic chargePhase;
      logic noiseFilterActive;
      logic biasCurrentEn;
      logic biasResistorEn;
      logic [3:0] biasLevelSel;
   } tkcc_analog_t;

   typedef struct packed {
      tkcc_cfgc_t cfg;
      logic [2:0] capSel;
      logic delayEn;
      logic randEn;
      logic noiseFlag;
      logic irqFlag;
      logic startBit;
      logic busy;
      tkcc_fsm_t fsm;
      logic runAuto;
      logic [16:0] cycleCnt;
      logic [4:0] runCnt;
      logic [10:0] delayCnt;
      logic [15:0] highCnt;
      logic [15:0] lowCnt;
      logic [15:0] baseline;
      logic [15:0] threshold;
      logic biasCur;
      logic biasRes;
      logic [3:0] biasSel;
      logic autoPrev;
      logic firstPending;
      logic wakeup;
      logic [7:0] lfsr;
      logic chargePhase;
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [7:0] rdata;
      logic [1:0] rresp;
   } tkcc_regs_t;

endpackage

// ===== logic/tkcc_top.sv
// Decided for this implementation: the AXI4-Lite slave port.
`include "tkcc_map.svh"

module tkcc_top #(
   parameter int AW = 20
) (
   // Clock and reset
   input logic clk,
   input logic resetn,
   // AXI4-Lite write
   input logic [AW-1:0] awaddr,
   input logic awvalid,
   output logic awready,
   input logic [31:0] wdata,
   input logic [3:0] wstrb,
   input logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input logic bready,
   // AXI4-Lite read
   input logic [AW-1:0] araddr,
   input logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input logic rready,
   // Settings held outside this block
   input logic autoMode,
   input logic [1:0] repeatCountSel,
   input logic [1:0] autoStartDelayCode,
   // Converter side
   input logic convTick,
   input logic compOut,
   input logic noiseDetect,
   output tkcc_pkg::tkcc_analog_t analog,
   output logic busy,
   output logic wakeup
);
   import tkcc_pkg::*;

   tkcc_regs_t s;
   tkcc_regs_t next_s;
   logic [16:0] cycLen;
   logic [4:0] runsTotal;
   logic [10:0] delayLen;
   logic [16:0] limit;
   logic [AW-3:0] wIdx;
   logic [AW-3:0] rIdx;
   logic [7:0] wByte;
   logic wTake;
   logic rTake;
   logic swStart;
   logic lastCycle;
   logic signed [16:0] avgDiff;
   logic signed [16:0] avgStep;

   always_comb
   begin
      case (s.cfg.cycleSel)
         3'h0: cycLen = `TKCC_CYC_0;
         3'h1: cycLen = `TKCC_CYC_1;
         3'h2: cycLen = `TKCC_CYC_2;
         3'h3: cycLen = `TKCC_CYC_3;
         3'h4: cycLen = `TKCC_CYC_4;
         3'h5: cycLen = `TKCC_CYC_5;
         3'h6: cycLen = `TKCC_CYC_6;
         default: cycLen = `TKCC_CYC_7;
      endcase
      case (repeatCountSel)
         2'h0: runsTotal = `TKCC_RPT_0;
         2'h1: runsTotal = `TKCC_RPT_1;
         2'h2: runsTotal = `TKCC_RPT_2;
         default: runsTotal = `TKCC_RPT_3;
      endcase
   end

   // Delay is (code + 1) units of 256 converter cycles
   assign delayLen = {3'({1'b0, autoStartDelayCode} + 3'h1),
                      8'h00} << (`TKCC_DLY_SHIFT - 8);
   assign limit = s.cfg.thrRel ? {1'b0, s.threshold} + {1'b0, s.baseline}
                               : {1'b0, s.threshold};
   assign wIdx = awaddr[AW-1:2];
   assign rIdx = araddr[AW-1:2];
   assign wByte = wdata[7:0];
   assign wTake = awvalid && wvalid && !s.awready && !s.bvalid && wstrb[0];
   assign rTake = arvalid && !s.arready && !s.rvalid;
   assign lastCycle = s.cycleCnt == cycLen - 17'h0_0001;
   assign avgDiff = $signed({1'b0, s.lowCnt}) - $signed({1'b0, s.baseline});
   // Four bits: the deepest average shifts by 8, which wraps in three
   assign avgStep = avgDiff >>> (4'(`TKCC_AVG_SHIFT) +
                                 {2'b00, s.cfg.avgDepth});

   always_comb
   begin
      next_s = s;
      next_s.wakeup = 1'b0;
      next_s.autoPrev = autoMode;
      next_s.awready = 1'b0;
      next_s.wready = 1'b0;
      next_s.arready = 1'b0;
      swStart = 1'b0;

      // Sequencer
      case (s.fsm)
         ST_IDLE:
         begin
            next_s.cycleCnt = 17'h0_0000;
            next_s.runCnt = 5'h00;
         end
         ST_DELAY:
         begin
            if (convTick)
            begin
               next_s.delayCnt = s.delayCnt + 11'h001;
               if (s.delayCnt == delayLen - 11'h001)
               begin
                  next_s.fsm = ST_RUN;
               end
            end
         end
         ST_RUN:
         begin
            if (convTick)
            begin
               // Noise stays reportable even with filtering off
               if (noiseDetect)
               begin
                  next_s.noiseFlag = 1'b1;
               end
               if (!(s.runAuto && s.cfg.noiseFiltEn && noiseDetect))
               begin
                  if (compOut)
                  begin
                     next_s.highCnt = s.highCnt + 16'h0001;
                  end
                  else
                  begin
                     next_s.lowCnt = s.lowCnt + 16'h0001;
                  end
               end
               next_s.lfsr = {s.lfsr[6:0],
                              s.lfsr[7] ^ s.lfsr[5] ^ s.lfsr[4] ^ s.lfsr[3]};
               next_s.chargePhase = s.randEn ? s.lfsr[0]
                                             : !s.chargePhase;
               next_s.cycleCnt = s.cycleCnt + 17'h0_0001;
               if (lastCycle)
               begin
                  next_s.cycleCnt = 17'h0_0000;
                  next_s.runCnt = s.runCnt + 5'h01;
                  if (s.runCnt == runsTotal - 5'h01)
                  begin
                     next_s.fsm = ST_DONE;
                  end
               end
            end
         end
         ST_DONE:
         begin
            next_s.irqFlag = 1'b1;
            next_s.startBit = 1'b0;
            if (s.runAuto)
            begin
               if (s.cfg.baseInit && s.firstPending)
               begin
                  next_s.baseline = s.lowCnt;
               end
               else
               begin
                  next_s.baseline = s.baseline + avgStep[15:0];
               end
               next_s.firstPending = 1'b0;
               // Detection only raises the flag when the limit is passed
               next_s.irqFlag = s.irqFlag || ({1'b0, s.lowCnt} > limit);
               next_s.wakeup = {1'b0, s.lowCnt} > limit;
            end
            next_s.fsm = ST_IDLE;
            next_s.busy = 1'b0;
         end
         default:
         begin
            next_s.fsm = ST_IDLE;
         end
      endcase

      // Write channel; software flag clears lose to a same-cycle set
      if (wTake)
      begin
         next_s.awready = 1'b1;
         next_s.wready = 1'b1;
         next_s.bvalid = 1'b1;
         next_s.bresp = `TKCC_RESP_OKAY;
         if (wIdx == (AW-2)'(`TKCC_IDX_CFGC))
         begin
            next_s.cfg = wByte;
         end
         else if (wIdx == (AW-2)'(`TKCC_IDX_CTRL))
         begin
            next_s.capSel = wByte[7:5];
            next_s.delayEn = wByte[4];
            next_s.randEn = wByte[3];
            if (!wByte[`TKCC_CTRL_NOISE] &&
                !(s.fsm == ST_RUN && convTick && noiseDetect))
            begin
               next_s.noiseFlag = 1'b0;
            end
            if (!wByte[`TKCC_CTRL_IRQ] && !(s.fsm == ST_DONE &&
                (!s.runAuto || {1'b0, s.lowCnt} > limit)))
            begin
               next_s.irqFlag = 1'b0;
            end
            swStart = wByte[`TKCC_CTRL_START];
         end
         else if (wIdx == (AW-2)'(`TKCC_IDX_BASEL))
         begin
            next_s.baseline[7:0] = wByte;
         end
         else if (wIdx == (AW-2)'(`TKCC_IDX_BASEH))
         begin
            next_s.baseline[15:8] = wByte;
         end
         else if (wIdx == (AW-2)'(`TKCC_IDX_THDL))
         begin
            next_s.threshold[7:0] = wByte;
         end
         else if (wIdx == (AW-2)'(`TKCC_IDX_THDH))
         begin
            next_s.threshold[15:8] = wByte;
         end
         else if (wIdx == (AW-2)'(`TKCC_IDX_BIAS))
         begin
            next_s.biasCur = wByte[`TKCC_BIAS_CUR];
            next_s.biasRes = wByte[`TKCC_BIAS_RES];
            next_s.biasSel = wByte[3:0];
         end
         else if (wIdx < (AW-2)'(`TKCC_IDX_HDTYL) ||
                  wIdx > (AW-2)'(`TKCC_IDX_LDTYH))
         begin
            next_s.bresp = `TKCC_RESP_SLVERR;
         end
      end
      else if (awvalid && wvalid && !s.awready && !s.bvalid)
      begin
         // Lane 0 off: accept and discard
         next_s.awready = 1'b1;
         next_s.wready = 1'b1;
         next_s.bvalid = 1'b1;
         next_s.bresp = `TKCC_RESP_OKAY;
      end
      else if (s.bvalid && bready)
      begin
         next_s.bvalid = 1'b0;
      end

      // Starts only from idle; a start while busy is dropped
      if (s.fsm == ST_IDLE && !s.busy)
      begin
         if (autoMode && !s.autoPrev)
         begin
            next_s.firstPending = 1'b1;
         end
         if ((swStart && !autoMode) || autoMode)
         begin
            next_s.startBit = swStart && !autoMode;
            next_s.runAuto = autoMode;
            next_s.busy = 1'b1;
            next_s.highCnt = 16'h0000;
            next_s.lowCnt = 16'h0000;
            next_s.delayCnt = 11'h000;
            next_s.fsm = (autoMode && s.delayEn) ? ST_DELAY : ST_RUN;
         end
      end

      // Read channel
      if (rTake)
      begin
         next_s.arready = 1'b1;
         next_s.rvalid = 1'b1;
         next_s.rresp = `TKCC_RESP_OKAY;
         next_s.rdata = `TKCC_RST_BYTE;
         case (16'(rIdx))
            `TKCC_IDX_CFGC: next_s.rdata = s.cfg;
            `TKCC_IDX_CTRL: next_s.rdata = {s.capSel, s.delayEn, s.randEn,
                                            s.noiseFlag, s.irqFlag,
                                            s.busy};
            `TKCC_IDX_HDTYL: next_s.rdata = s.highCnt[7:0];
            `TKCC_IDX_HDTYH: next_s.rdata = s.highCnt[15:8];
            `TKCC_IDX_LDTYL: next_s.rdata = s.lowCnt[7:0];
            `TKCC_IDX_LDTYH: next_s.rdata = s.lowCnt[15:8];
            `TKCC_IDX_BASEL: next_s.rdata = s.baseline[7:0];
            `TKCC_IDX_BASEH: next_s.rdata = s.baseline[15:8];
            `TKCC_IDX_THDL: next_s.rdata = s.threshold[7:0];
            `TKCC_IDX_THDH: next_s.rdata = s.threshold[15:8];
            `TKCC_IDX_BIAS: next_s.rdata = {s.biasCur, s.biasRes, 2'h0,
                                            s.biasSel};
            default: next_s.rresp = `TKCC_RESP_SLVERR;
         endcase
         if (rIdx[AW-3:16] != '0)
         begin
            next_s.rresp = `TKCC_RESP_SLVERR;
            next_s.rdata = `TKCC_RST_BYTE;
         end
      end
      else if (s.rvalid && rready)
      begin
         next_s.rvalid = 1'b0;
      end
   end

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         s <= '0;
         s.lfsr <= 8'h01;
      end
      else
      begin
         s <= next_s;
      end
   end

   assign awready = s.awready;
   assign wready = s.wready;
   assign bvalid = s.bvalid;
   assign bresp = s.bresp;
   assign arready = s.arready;
   assign rvalid = s.rvalid;
   assign rresp = s.rresp;
   assign rdata = {24'h00_0000, s.rdata};
   assign busy = s.busy;
   assign wakeup = s.wakeup;
   assign analog = '{chargeCapSel: s.capSel, randomTimingEn: s.randEn,
                     chargePhase: s.chargePhase,
                     noiseFilterActive: s.runAuto && s.cfg.noiseFiltEn,
                     biasCurrentEn: s.biasCur, biasResistorEn: s.biasRes,
                     biasLevelSel: s.biasSel};

   AST_START_CLR: assert property (@(posedge clk) disable iff (!resetn)
      $fell(s.busy) |-> !s.startBit) else $error("start bit not cleared");
   AST_BUSY: assert property (@(posedge clk) disable iff (!resetn)
      s.fsm != ST_IDLE |-> s.busy) else $error("busy low while running");
   AST_SEQ_LEN: assert property (@(posedge clk) disable iff (!resetn)
      s.fsm == ST_RUN |-> s.cycleCnt < cycLen) else $error("cycle overrun");
   AST_SEQ_END: assert property (@(posedge clk) disable iff (!resetn)
      s.fsm == ST_RUN && convTick && lastCycle &&
      s.runCnt == runsTotal - 5'h01 |=> s.fsm == ST_DONE)
      else $error("sequence did not end");
   AST_IRQ: assert property (@(posedge clk) disable iff (!resetn)
      s.fsm == ST_DONE && (!s.runAuto || {1'b0, s.lowCnt} > limit)
      |=> s.irqFlag) else $error("irq flag not set");
   AST_DETECT: assert property (@(posedge clk) disable iff (!resetn)
      s.fsm == ST_DONE && s.runAuto && {1'b0, s.lowCnt} > limit
      |=> s.wakeup ##1 !s.wakeup) else $error("wake-up pulse wrong");
   AST_NO_DETECT: assert property (@(posedge clk) disable iff (!resetn)
      s.fsm == ST_DONE && s.cfg.thrRel &&
      {1'b0, s.lowCnt} <= {1'b0, s.threshold} + {1'b0, s.baseline}
      |=> !s.wakeup) else $error("wake-up below limit");
   AST_NOISE: assert property (@(posedge clk) disable iff (!resetn)
      s.fsm == ST_RUN && convTick && noiseDetect |=> s.noiseFlag)
      else $error("noise flag not set");
   AST_DELAY: assert property (@(posedge clk) disable iff (!resetn)
      s.fsm == ST_DELAY ##1 s.fsm == ST_RUN |-> $past(s.delayCnt) ==
      delayLen - 11'h001) else $error("auto delay length wrong");
   AST_RD_ANSWER: assert property (@(posedge clk) disable iff (!resetn)
      rTake |=> s.rvalid && s.arready) else $error("read not answered");
   COV_NORMAL: cover property (@(posedge clk) disable iff (!resetn)
      s.fsm == ST_DONE && !s.runAuto);
   COV_WAKE: cover property (@(posedge clk) disable iff (!resetn)
      s.wakeup);
   COV_DELAY: cover property (@(posedge clk) disable iff (!resetn)
      s.fsm == ST_DELAY ##1 s.fsm == ST_RUN);
endmodule

// ===== dv/tkcc_front_model.sv
module tkcc_front_model (
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   // Settings from the bench
   input wire logic [3:0] tickGap,
   input wire logic compLevel,
   input wire logic noiseOn,
   // Converter side of the block
   output logic convTick,
   output logic compOut,
   output logic noiseDetect
);
   logic [3:0] cnt;
   logic tickNow;

   assign tickNow = (cnt == tickGap - 4'h1);

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         cnt <= 4'h0;
         convTick <= 1'b0;
         compOut <= 1'b0;
         noiseDetect <= 1'b0;
      end
      else
      begin
         cnt <= tickNow ? 4'h0 : cnt + 4'h1;
         convTick <= tickNow;
         // Only valid on ticks; toggles between them to expose stray sampling
         compOut <= tickNow ? compLevel : ~compOut;
         noiseDetect <= tickNow & noiseOn;
      end
   end
endmodule

// ===== dv/tkcc_tb.sv
`include "tkcc_map.svh"

module tb;
   timeunit 1ns;
   timeprecision 1ns;
   import tkcc_pkg::*;

   logic clk, resetn, autoMode, busy, wakeup;
   logic [19:0] awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [3:0] wstrb, tickGap;
   logic [1:0] bresp, rresp, repeatCountSel, autoStartDelayCode;
   logic awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready;
   logic convTick, compOut, noiseDetect, compLevel, noiseOn;
   tkcc_analog_t analog;
   logic [5:0] biasPins;
   logic [3:0] capPins;
   int errors, n_tests, wakeCnt, cycNow;
   localparam logic [15:0] REGS [11] = '{`TKCC_IDX_CFGC, `TKCC_IDX_CTRL,
      `TKCC_IDX_HDTYL, `TKCC_IDX_HDTYH, `TKCC_IDX_LDTYL, `TKCC_IDX_LDTYH,
      `TKCC_IDX_BASEL, `TKCC_IDX_BASEH, `TKCC_IDX_THDL, `TKCC_IDX_THDH,
      `TKCC_IDX_BIAS};

   assign biasPins = {analog.biasCurrentEn, analog.biasResistorEn,
      analog.biasLevelSel};
   assign capPins = {analog.chargeCapSel, analog.randomTimingEn};

   tkcc_top #(.AW(20)) dut (
      .clk(clk), .resetn(resetn), .awaddr(awaddr), .awvalid(awvalid),
      .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
      .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
      .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
      .rresp(rresp), .rvalid(rvalid), .rready(rready), .autoMode(autoMode),
      .repeatCountSel(repeatCountSel),
      .autoStartDelayCode(autoStartDelayCode), .convTick(convTick),
      .compOut(compOut), .noiseDetect(noiseDetect), .analog(analog),
      .busy(busy), .wakeup(wakeup)
   );

   tkcc_front_model model (
      .clk(clk), .resetn(resetn), .tickGap(tickGap), .compLevel(compLevel),
      .noiseOn(noiseOn), .convTick(convTick), .compOut(compOut),
      .noiseDetect(noiseDetect)
   );

   always #25 clk = ~clk;

   always @(posedge clk)
   begin
      cycNow <= cycNow + 1;
      if (wakeup === 1'b1)
         wakeCnt <= wakeCnt + 1;
   end

   task automatic final_report();
      if (errors == 0 && n_tests > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   task automatic check(input logic [31:0] got, input logic [31:0] exp,
      input string what);
      n_tests++;
      if (got !== exp)
      begin
         errors++;
         $display("BAD %0t %s: got %h expected %h", $time, what, got, exp);
      end
   endtask

   task automatic hang(input string what);
      errors++;
      $display("BAD %0t no answer: %s", $time, what);
      final_report();
   endtask

   task automatic inwin(input int d, input int exp, input string what);
      check(32'(d >= exp - 8 && d <= exp + 32), 32'h0000_0001, what);
   endtask

   task automatic wr(input logic [15:0] idx, input logic [7:0] val);
      int n;
      bit gotA, gotW, gotB;
      n = 0;
      {gotA, gotW, gotB} = '0;
      @(posedge clk);
      awaddr <= {2'h0, idx, 2'h0};
      wdata <= {24'h00_0000, val};
      wstrb <= 4'hf;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!(gotA && gotW && gotB))
      begin
         @(posedge clk);
         n++;
         gotA = gotA | (awready === 1'b1);
         gotW = gotW | (wready === 1'b1);
         if (gotA)
            awvalid <= 1'b0;
         if (gotW)
            wvalid <= 1'b0;
         if (!gotB && bvalid === 1'b1)
         begin
            gotB = 1;
            bready <= 1'b0;
            check(32'(bresp), 32'(`TKCC_RESP_OKAY), "write response");
         end
         if (n > 100)
            hang("write");
      end
   endtask

   task automatic rd(input logic [17:0] idx, output logic [31:0] d,
      output logic [1:0] r);
      int n;
      bit gotA, gotR;
      n = 0;
      {gotA, gotR} = '0;
      @(posedge clk);
      araddr <= {idx, 2'h0};
      arvalid <= 1'b1;
      rready <= 1'b1;
      while (!(gotA && gotR))
      begin
         @(posedge clk);
         n++;
         gotA = gotA | (arready === 1'b1);
         if (gotA)
            arvalid <= 1'b0;
         if (!gotR && rvalid === 1'b1)
         begin
            gotR = 1;
            rready <= 1'b0;
            d = rdata;
            r = rresp;
         end
         if (n > 100)
            hang("read");
      end
   endtask

   task automatic chk(input logic [15:0] idx, input logic [7:0] exp,
      input string what);
      logic [31:0] d;
      logic [1:0] r;
      rd(18'(idx), d, r);
      check(d, {24'h00_0000, exp}, what);
      check(32'(r), 32'(`TKCC_RESP_OKAY), what);
   endtask

   task automatic wait_done(input int limit);
      int n;
      bit seen;
      n = 0;
      seen = 0;
      while (!(seen && busy === 1'b0))
      begin
         @(posedge clk);
         n++;
         seen = seen | (busy === 1'b1);
         if (n > limit)
            hang("conversion end");
      end
   endtask

   // Scan window, not a timeout: no wake-up is a legal outcome
   task automatic auto_run(input int limit, output bit woke, output int cyc);
      int base;
      base = wakeCnt;
      cyc = 0;
      @(posedge clk);
      autoMode <= 1'b1;
      while (wakeCnt == base && cyc < limit)
      begin
         @(posedge clk);
         cyc++;
      end
      woke = (wakeCnt != base);
   endtask

   task automatic auto_stop();
      int n;
      n = 0;
      @(posedge clk);
      autoMode <= 1'b0;
      while (busy !== 1'b0 || n < 4)
      begin
         @(posedge clk);
         n++;
         if (n > 10000)
            hang("auto stop");
      end
   endtask

   task automatic t_reset();
      logic [31:0] d;
      logic [1:0] r;
      foreach (REGS[i])
         chk(REGS[i], `TKCC_RST_BYTE, "reset value");
      rd(18'h1_0000, d, r);
      check(32'(r), 32'(`TKCC_RESP_SLVERR), "unmapped read");
   endtask

   task automatic t_regs();
      wr(`TKCC_IDX_BASEL, 8'ha5);
      wr(`TKCC_IDX_THDH, 8'hc3);
      wr(`TKCC_IDX_BIAS, 8'h8f);
      wr(`TKCC_IDX_CTRL, 8'hf8);
      wr(`TKCC_IDX_HDTYL, 8'hff);
      chk(`TKCC_IDX_BASEL, 8'ha5, "baseline low");
      chk(`TKCC_IDX_THDH, 8'hc3, "threshold high");
      chk(`TKCC_IDX_BIAS, 8'h8f, "bias byte");
      chk(`TKCC_IDX_CTRL, 8'hf8, "control byte");
      chk(`TKCC_IDX_HDTYL, 8'h00, "count write");
      check(32'(biasPins), 32'h0000_002f, "bias current");
      check(32'(capPins), 32'h0000_000f, "cap and random");
      wr(`TKCC_IDX_BIAS, 8'h45);
      wr(`TKCC_IDX_CTRL, 8'h40);
      check(32'(biasPins), 32'h0000_0015, "bias resistor");
      check(32'(capPins), 32'h0000_0004, "cap fixed timing");
      wr(`TKCC_IDX_CTRL, 8'h00);
   endtask

   task automatic t_normal();
      int t0;
      wr(`TKCC_IDX_CFGC, 8'h08);
      repeatCountSel <= 2'h1;
      compLevel <= 1'b1;
      wr(`TKCC_IDX_CTRL, 8'h01);
      t0 = cycNow;
      chk(`TKCC_IDX_CTRL, 8'h01, "busy while running");
      wait_done(20000);
      inwin(cycNow - t0, 16384, "sequence length");
      chk(`TKCC_IDX_HDTYH, 8'h20, "high count");
      chk(`TKCC_IDX_HDTYL, 8'h00, "high count low");
      chk(`TKCC_IDX_LDTYH, 8'h00, "low count");
      chk(`TKCC_IDX_CTRL, 8'h02, "done flags");
      wr(`TKCC_IDX_CTRL, 8'h02);
      chk(`TKCC_IDX_CTRL, 8'h02, "irq write one");
      wr(`TKCC_IDX_CTRL, 8'h00);
      chk(`TKCC_IDX_CTRL, 8'h00, "irq cleared");
   endtask

   task automatic t_noise();
      repeatCountSel <= 2'h0;
      compLevel <= 1'b0;
      noiseOn <= 1'b1;
      wr(`TKCC_IDX_CFGC, 8'h00);
      wr(`TKCC_IDX_CTRL, 8'h01);
      wait_done(5000);
      noiseOn <= 1'b0;
      chk(`TKCC_IDX_CTRL, 8'h06, "noise and irq");
      chk(`TKCC_IDX_LDTYH, 8'h04, "low count");
      chk(`TKCC_IDX_HDTYH, 8'h00, "counts restart");
      wr(`TKCC_IDX_CTRL, 8'h04);
      chk(`TKCC_IDX_CTRL, 8'h04, "irq cleared alone");
      wr(`TKCC_IDX_CTRL, 8'h00);
      chk(`TKCC_IDX_CTRL, 8'h00, "noise cleared");
   endtask

   task automatic t_auto();
      bit woke;
      int cyc;
      wr(`TKCC_IDX_THDH, 8'h00);
      autoStartDelayCode <= 2'h1;
      for (int i = 0; i < 2; i++)
      begin
         wr(`TKCC_IDX_CFGC, 8'h04 | 8'(i));
         wr(`TKCC_IDX_CTRL, 8'(i << 4));
         wr(`TKCC_IDX_BASEH, 8'h5a);
         auto_run(4000, woke, cyc);
         check(32'(woke), 32'h0000_0001, "wake-up");
         inwin(cyc, 2048 + i * 1024, "auto start");
         check(32'(analog.noiseFilterActive), 32'(i), "filter");
         auto_stop();
         chk(`TKCC_IDX_BASEH, 8'h04, "first count high");
         chk(`TKCC_IDX_BASEL, 8'h00, "first count low");
         chk(`TKCC_IDX_CTRL, 8'h02 | 8'(i << 4), "auto irq");
         wr(`TKCC_IDX_CTRL, 8'h00);
      end
   endtask

   task automatic t_rel();
      bit woke;
      int cyc;
      wr(`TKCC_IDX_CFGC, 8'h02);
      wr(`TKCC_IDX_BASEH, 8'h03);
      wr(`TKCC_IDX_BASEL, 8'h00);
      wr(`TKCC_IDX_THDL, 8'hf0);
      auto_run(4000, woke, cyc);
      check(32'(woke), 32'h0000_0001, "above limit");
      chk(`TKCC_IDX_BASEL, 8'h08, "moving average");
      chk(`TKCC_IDX_BASEH, 8'h03, "average start");
      auto_stop();
      wr(`TKCC_IDX_BASEL, 8'h00);
      wr(`TKCC_IDX_THDL, 8'h00);
      wr(`TKCC_IDX_THDH, 8'h01);
      auto_run(2600, woke, cyc);
      check(32'(woke), 32'h0000_0000, "equal to limit");
      auto_stop();
      chk(`TKCC_IDX_THDH, 8'h01, "threshold kept");
   endtask

   initial
   begin
      clk = 1'b0;
      resetn = 1'b0;
      {awaddr, araddr, wdata, wstrb} = '0;
      {awvalid, wvalid, bready, arvalid, rready, autoMode} = '0;
      {repeatCountSel, autoStartDelayCode, compLevel, noiseOn} = '0;
      tickGap = 4'h2;
      {errors, n_tests, wakeCnt, cycNow} = '0;
      repeat (8) @(posedge clk);
      resetn <= 1'b1;
      t_reset();
      t_regs();
      t_normal();
      t_noise();
      t_auto();
      t_rel();
      final_report();
   end
endmodule
